//--- hw/sdm_measure.sv
// What this block does
// R1 - Count clock falling edges step counter 0..99
// R2 - Bit phase timing is count divided by 100
// R3 - Start window low during first start transition
// R4 - Decades use 1-2-4-2 weighted codes
// R5 - Four steps to code 1011 for five
// R6 - Binary up to 1111, then back to zero
// R7 - Complemented outputs count down 99 to zero
// R8 - Half select gives offered count 49-0-49
// R9 - Offered count zero at ideal transition instant
// R10 - Strobe loads offered count; held until next
// R11 - Captured value equals displacement, 0 to 50
// R12 - Add one during the down-count half
// R13 - Early transitions in either direction clear marking polarity
// R14 - Late transitions set polarity from bit phase
// R15 - Bias: falling edges pass one timing pulse
// R16 - End: all edges except first start transition
// R17 - End capture off in synchronous operation
// R18 - Peak: strobe only while offered exceeds stored
// R19 - Single transition: selected line gates strobe
// R20 - Transition select off in synchronous operation
// R21 - Manual reset falling edge clears register
// R22 - Auto reset clears register every five seconds
// R23 - Start sync clears both counters
// R24 - Data synchronised before edge detection
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module sdm_measure #(
  parameter logic [30:0] AUTO_RESET_CYCLES =
    31'(sdm_pkg::AUTO_RESET_NS / sdm_pkg::SYS_CLK_NS)
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  // Signal under test and timing
  input  wire logic                          count_clock_100x,
  input  wire logic                          data_under_test,
  // Register port
  input  wire logic [sdm_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic [31:0]                        reg_rdata,
  // Measurement results
  output logic                               bit_phase_timing,
  output logic                               capture_strobe,
  output logic                               polarity_marking,
  output logic                               start_transition_window,
  output logic                               peak_enable_flag,
  output logic                               add_one_compensation,
  output logic [7:0]                         distortion_bcd,
  output logic [sdm_pkg::LINE_HI:sdm_pkg::LINE_LO] transition_lines_n
);

  sdm_pkg::sdm_ctrl_t ctrl;
  logic        cc_q;
  logic        cc_prev;
  logic        d_s1;
  logic        d_s2;
  logic        d_s3;
  logic        edge_pend;
  logic        in_char;
  logic        peak_compare_flag;
  logic        manual_prev;
  logic [3:0]  trans_cnt;
  logic [6:0]  distortion;
  logic [30:0] auto_cnt;
  logic [3:0]  units_code;
  logic [3:0]  tens_code;
  logic        units_wrap;

  // Decode and selection
  wire logic       gated_timing_pulse = cc_prev && !cc_q;                  // [R1]
  wire logic       fall_ev   = d_s3 && !d_s2;                              // [R24]
  wire logic       rise_ev   = !d_s3 && d_s2;
  wire logic       any_ev    = fall_ev || rise_ev;
  wire logic       start_ev  = fall_ev && !in_char && !ctrl.sync_op;
  wire logic       upper     = tens_code[3];
  wire logic [3:0] inv_units = ~units_code;                                // [R7]
  wire logic [3:0] inv_tens  = ~tens_code;
  wire logic [6:0] down_val  = 7'(sdm_pkg::sdm_code_to_val(inv_tens)) * sdm_pkg::DEC_BASE
                               + 7'(sdm_pkg::sdm_code_to_val(inv_units));
  wire logic [6:0] count_val = sdm_pkg::LAST_LOW + sdm_pkg::LAST_LOW + 7'h1 - down_val;
  // Lower half offers the inverted up-count, upper half the down-count mirror
  wire logic [6:0] offered   = upper ? count_val - sdm_pkg::HALF_COUNT              // [R8]
                                     : sdm_pkg::LAST_LOW - count_val;              // [R9]
  wire logic       is_bias   = ctrl.mode == sdm_pkg::MODE_BIAS;
  wire logic       is_end    = ctrl.mode == sdm_pkg::MODE_END;
  wire logic       is_peak   = ctrl.mode == sdm_pkg::MODE_PEAK;
  wire logic       mode_ok   = (is_bias && fall_ev)                               // [R15]
                            || (is_end && any_ev && !ctrl.sync_op && !start_ev)   // [R16] [R17]
                            || (is_peak && any_ev);                               // [R18]
  wire logic       sel_off   = (ctrl.transition_select == sdm_pkg::TRANS_NONE)
                            || (ctrl.transition_select > sdm_pkg::TRANS_LAST)
                            || ctrl.sync_op;                                      // [R20]
  wire logic       sel_ok    = sel_off || (in_char &&
                               trans_cnt == ctrl.transition_select);              // [R19]
  wire logic       arm       = mode_ok && sel_ok;
  wire logic       fire      = edge_pend && gated_timing_pulse &&
                               (!is_peak || peak_compare_flag);
  wire logic       manual_fall = manual_prev && !ctrl.manual_req;                 // [R21]
  wire logic       auto_tick = ctrl.auto_reset &&
                               auto_cnt == AUTO_RESET_CYCLES - 31'h1;             // [R22]
  wire logic       dist_clear = manual_fall || auto_tick;
  wire logic [6:0] display   = distortion + 7'(add_one_compensation);            // [R12]
  wire logic [3:0] disp_tens = 4'(display / sdm_pkg::DEC_BASE);
  wire logic [3:0] disp_unit = 4'(display % sdm_pkg::DEC_BASE);
  wire logic       bpt_rise  = upper && !bit_phase_timing;
  wire logic       wr_ctrl   = reg_wr && reg_addr == sdm_pkg::ADDR_CTRL;

  wire sdm_pkg::sdm_status_t status = '{bit_phase_timing, peak_enable_flag,
                                        add_one_compensation, polarity_marking,
                                        distortion_bcd};
  wire sdm_pkg::sdm_count_t  counts = '{trans_cnt, tens_code, units_code};
  wire logic [31:0] rd_mux = (reg_addr == sdm_pkg::ADDR_CTRL)   ? 32'(ctrl)   :
                             (reg_addr == sdm_pkg::ADDR_STATUS) ? 32'(status) :
                             (reg_addr == sdm_pkg::ADDR_COUNT)  ? 32'(counts) : 32'h0;

  logic [sdm_pkg::LINE_HI:sdm_pkg::LINE_LO] next_lines_n;
  always_comb begin
    for (int k = sdm_pkg::LINE_LO; k <= sdm_pkg::LINE_HI; k++) begin
      next_lines_n[k] = !(in_char && trans_cnt == 4'(k));                        // [R19]
    end
  end

  // Two decades; tens follows each units wrap
  sdm_decade u_units (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .step    (gated_timing_pulse),                                              // [R1]
    .clear   (start_ev),                                                        // [R23]
    .code    (units_code),
    .wrap    (units_wrap)
  );

  sdm_decade u_tens (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .step    (units_wrap),                                                      // [R1]
    .clear   (start_ev),                                                        // [R23]
    .code    (tens_code),
    .wrap    ()
  );

  // Input sampling; the second and third data stages feed edge logic
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cc_q    <= 1'b0;
      cc_prev <= 1'b0;
      d_s1    <= 1'b1;
      d_s2    <= 1'b1;
      d_s3    <= 1'b1;
    end else begin
      cc_q    <= count_clock_100x;
      cc_prev <= cc_q;
      d_s1    <= data_under_test;                                               // [R24]
      d_s2    <= d_s1;
      d_s3    <= d_s2;
    end
  end

  // Register port
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl        <= sdm_pkg::CTRL_RESET;
      manual_prev <= 1'b0;
      reg_rdata   <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= sdm_pkg::sdm_ctrl_t'(reg_wdata[sdm_pkg::CTRL_W-1:0]);
      end
      manual_prev <= ctrl.manual_req;
      reg_rdata   <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // Bit phase, start window and transition counter
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_phase_timing        <= 1'b0;
      start_transition_window <= 1'b1;
      in_char                 <= 1'b0;
      trans_cnt               <= sdm_pkg::TRANS_NONE;
      transition_lines_n      <= '1;
    end else begin
      bit_phase_timing   <= upper;                                              // [R2]
      transition_lines_n <= next_lines_n;
      if (start_ev) begin
        start_transition_window <= 1'b0;                                        // [R3]
      end else if (gated_timing_pulse) begin
        start_transition_window <= 1'b1;
      end
      if (start_ev) begin
        in_char   <= 1'b1;                                                      // [R23]
        trans_cnt <= sdm_pkg::TRANS_FIRST;
      end else if (ctrl.sync_op) begin
        in_char   <= 1'b0;
        trans_cnt <= sdm_pkg::TRANS_NONE;
      end else if (in_char && bpt_rise) begin
        if (trans_cnt == sdm_pkg::TRANS_LAST) begin
          in_char   <= 1'b0;
          trans_cnt <= sdm_pkg::TRANS_NONE;
        end else begin
          trans_cnt <= trans_cnt + 4'h1;
        end
      end
    end
  end

  // Capture path; a capture in the clearing cycle wins
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      edge_pend            <= 1'b0;
      capture_strobe       <= 1'b0;
      distortion           <= 7'h0;
      add_one_compensation <= 1'b0;
      peak_compare_flag    <= 1'b0;
      peak_enable_flag     <= 1'b0;
      polarity_marking     <= 1'b0;
      distortion_bcd       <= 8'h0;
    end else begin
      if (arm) begin
        edge_pend <= 1'b1;
      end else if (gated_timing_pulse) begin
        edge_pend <= 1'b0;                                                      // [R15]
      end
      capture_strobe <= fire;
      if (fire) begin
        distortion           <= offered;                                        // [R10] [R11]
        add_one_compensation <= !upper;                                         // [R12]
      end else if (dist_clear) begin
        distortion           <= 7'h0;                                           // [R21] [R22]
        add_one_compensation <= 1'b0;
      end
      peak_compare_flag <= offered > distortion;                                // [R18]
      peak_enable_flag  <= is_peak && (offered > distortion);
      if (any_ev) begin
        polarity_marking <= upper;                                              // [R13] [R14]
      end
      distortion_bcd <= {sdm_pkg::sdm_val_to_code(disp_tens),
                         sdm_pkg::sdm_val_to_code(disp_unit)};                  // [R4]
    end
  end

  // Five second timer, held at zero while auto reset is off
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      auto_cnt <= 31'h0;
    end else if (!ctrl.auto_reset || auto_tick) begin
      auto_cnt <= 31'h0;
    end else begin
      auto_cnt <= auto_cnt + 31'h1;                                             // [R22]
    end
  end

  property p_five_code;
    @(posedge sys_clk) disable iff (sys_rst)
      gated_timing_pulse && !start_ev && units_code == sdm_pkg::DEC_FOUR
      |=> units_code == sdm_pkg::DEC_FIVE;
  endproperty
  a_five_code: assert property (p_five_code) else $error("four did not step to five"); // [R5]

  property p_nine_wrap;
    @(posedge sys_clk) disable iff (sys_rst)
      gated_timing_pulse && !start_ev && units_code == sdm_pkg::DEC_NINE
      |=> units_code == sdm_pkg::DEC_ZERO && $changed(tens_code);
  endproperty
  a_nine_wrap: assert property (p_nine_wrap) else $error("units wrap lost"); // [R6]

  property p_legal_code;
    @(posedge sys_clk) disable iff (sys_rst)
      !(units_code > sdm_pkg::DEC_FOUR && units_code < sdm_pkg::DEC_FIVE);
  endproperty
  a_legal_code: assert property (p_legal_code) else $error("illegal decade code"); // [R4]

  property p_offered_range;
    @(posedge sys_clk) disable iff (sys_rst)
      offered <= sdm_pkg::LAST_LOW && display <= sdm_pkg::HALF_COUNT;
  endproperty
  a_offered_range: assert property (p_offered_range) else $error("offered out of range"); // [R11]

  property p_capture_load;
    @(posedge sys_clk) disable iff (sys_rst)
      fire |=> capture_strobe && distortion == $past(offered)
               && add_one_compensation == !$past(upper);
  endproperty
  a_capture_load: assert property (p_capture_load) else $error("capture not loaded"); // [R10]

  property p_hold;
    @(posedge sys_clk) disable iff (sys_rst)
      !fire && !dist_clear |=> $stable(distortion);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without cause"); // [R10]

  property p_peak_gate;
    @(posedge sys_clk) disable iff (sys_rst)
      capture_strobe && $past(is_peak) |-> $past(peak_compare_flag);
  endproperty
  a_peak_gate: assert property (p_peak_gate) else $error("peak strobe without flag"); // [R18]

  property p_sync_end;
    @(posedge sys_clk) disable iff (sys_rst)
      ctrl.sync_op && is_end && !edge_pend ##1 ctrl.sync_op && is_end |-> !edge_pend;
  endproperty
  a_sync_end: assert property (p_sync_end) else $error("end capture in sync operation"); // [R17]

  property p_start_sync;
    @(posedge sys_clk) disable iff (sys_rst)
      start_ev |=> units_code == sdm_pkg::DEC_ZERO && tens_code == sdm_pkg::DEC_ZERO
                   && trans_cnt == sdm_pkg::TRANS_FIRST && !start_transition_window;
  endproperty
  a_start_sync: assert property (p_start_sync) else $error("start sync not applied"); // [R23]

  property p_polarity;
    @(posedge sys_clk) disable iff (sys_rst)
      any_ev |=> polarity_marking == $past(upper);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity not updated"); // [R13]

  property p_manual;
    @(posedge sys_clk) disable iff (sys_rst)
      manual_fall && !fire |=> distortion == 7'h0 ##1 distortion_bcd == 8'h0;
  endproperty
  a_manual: assert property (p_manual) else $error("manual reset missed"); // [R21]

  property p_edge_once;
    @(posedge sys_clk) disable iff (sys_rst)
      any_ev |=> !any_ev;
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge lasted two cycles"); // [R24]

  c_bias_capture: cover property (@(posedge sys_clk) disable iff (sys_rst)
                                  is_bias && capture_strobe);
  c_peak_capture: cover property (@(posedge sys_clk) disable iff (sys_rst)
                                  is_peak && capture_strobe);
  c_auto_clear:   cover property (@(posedge sys_clk) disable iff (sys_rst) auto_tick);
  c_start_sync:   cover property (@(posedge sys_clk) disable iff (sys_rst)
                                  start_ev);

endmodule : sdm_measure
`default_nettype wire

//--- hw/sdm_pkg.sv
`default_nettype none
package sdm_pkg;

  // Clock and long timer
  localparam longint SYS_CLK_NS    = 4;
  localparam longint AUTO_RESET_NS = 5_000_000_000;

  // Decade codes with 1-2-4-2 weighting
  localparam logic [3:0] DEC_ZERO = 4'h0;
  localparam logic [3:0] DEC_FOUR = 4'h4;
  localparam logic [3:0] DEC_FIVE = 4'hB;
  localparam logic [3:0] DEC_NINE = 4'hF;
  localparam logic [3:0] DEC_GAP  = 4'h6;

  // Count halves and decimal base
  localparam logic [6:0] HALF_COUNT = 7'h32;
  localparam logic [6:0] LAST_LOW   = 7'h31;
  localparam logic [6:0] DEC_BASE   = 7'h0A;

  // Transition counter range
  localparam logic [3:0] TRANS_NONE  = 4'h0;
  localparam logic [3:0] TRANS_FIRST = 4'h1;
  localparam logic [3:0] TRANS_LAST  = 4'h9;
  localparam int         LINE_LO     = 1;
  localparam int         LINE_HI     = 9;

  // Register port
  localparam int         ADDR_W      = 4;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_COUNT  = 4'h8;

  typedef enum logic [1:0] {
    MODE_OFF  = 2'b00,
    MODE_BIAS = 2'b01,
    MODE_END  = 2'b10,
    MODE_PEAK = 2'b11
  } sdm_mode_t;

  typedef struct packed {
    logic       manual_req;
    logic       auto_reset;
    logic       sync_op;
    logic [3:0] transition_select;
    sdm_mode_t  mode;
  } sdm_ctrl_t;

  localparam int        CTRL_W     = $bits(sdm_ctrl_t);
  localparam sdm_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 1'b0, 4'h0, MODE_OFF};

  typedef struct packed {
    logic       bit_phase;
    logic       peak_flag;
    logic       add_one;
    logic       marking;
    logic [7:0] display_bcd;
  } sdm_status_t;

  typedef struct packed {
    logic [3:0] transition;
    logic [3:0] tens;
    logic [3:0] units;
  } sdm_count_t;

  function automatic logic [3:0] sdm_code_to_val(input logic [3:0] c);
    sdm_code_to_val = 4'({3'h0, c[0]}) + 4'({2'h0, c[1], 1'h0}) +
                      4'({1'h0, c[2], 2'h0}) + 4'({2'h0, c[3], 1'h0});
  endfunction : sdm_code_to_val

  function automatic logic [3:0] sdm_val_to_code(input logic [3:0] v);
    sdm_val_to_code = (v > DEC_FOUR) ? v + DEC_GAP : v;
  endfunction : sdm_val_to_code

endpackage : sdm_pkg
`default_nettype wire

//--- hw/sdm_decade.sv
`timescale 1ns/1ps
`default_nettype none
module sdm_decade (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       step,
  input  wire logic       clear,
  // Count
  output logic [3:0]      code,
  output logic            wrap
);

  logic [3:0] next_code;

  assign wrap = step && !clear && (code == sdm_pkg::DEC_NINE);
  assign next_code = (code == sdm_pkg::DEC_FOUR) ? sdm_pkg::DEC_FIVE :   // [R5]
                     (code == sdm_pkg::DEC_NINE) ? sdm_pkg::DEC_ZERO :   // [R6]
                     code + 4'h1;                                        // [R4]

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      code <= sdm_pkg::DEC_ZERO;
    end else if (clear) begin
      code <= sdm_pkg::DEC_ZERO;
    end else if (step) begin
      code <= next_code;
    end
  end

endmodule : sdm_decade
`default_nettype wire

//--- test/sdm_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdm_line_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Timing from the bench
  input  wire logic count_clock_100x,
  // Line under test
  output logic      data_under_test
);
  logic       clk_q;
  logic [6:0] steps;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_q <= 1'b0;
      steps <= 7'h00;
    end else begin
      clk_q <= count_clock_100x;
      if (clk_q && !count_clock_100x) begin
        steps <= (steps == 7'h63) ? 7'h00 : steps + 7'h01;
      end
    end
  end
  // Idle line rests at mark
  initial data_under_test = 1'b1;
  // Edge placed just after a count clock rise, so it lands before the next step
  task automatic move_at(input logic [6:0] pos, input logic lvl);
    do @(posedge sys_clk);
    while (!(steps == pos && !clk_q && count_clock_100x));
    data_under_test <= lvl;
  endtask : move_at
endmodule : sdm_line_model
`default_nettype wire

//--- test/tb_sdm_measure.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); \
  end \
end
module tb_sdm_measure;
  localparam int AUTO_CYC = 200;
  logic        sys_clk          = 1'b0;
  logic        sys_rst          = 1'b1;
  logic        count_clock_100x = 1'b0;
  logic        data_under_test;
  logic [3:0]  reg_addr         = 4'h0;
  logic [31:0] reg_wdata        = 32'h0;
  logic        reg_wr           = 1'b0;
  logic        reg_rd           = 1'b0;
  logic [31:0] reg_rdata;
  logic        bit_phase_timing;
  logic        capture_strobe;
  logic        polarity_marking;
  logic        start_transition_window;
  logic        peak_enable_flag;
  logic        add_one_compensation;
  logic [7:0]  distortion_bcd;
  logic [9:1]  transition_lines_n;
  logic [31:0] rd_val;
  logic [2:0]  div_cnt          = 3'h0;
  logic        sync_on          = 1'b1;
  int          err_total        = 0;
  int          samples_checked  = 0;
  int          strobes          = 0;
  int          cycles           = 0;
  int          n;
  sdm_measure #(.AUTO_RESET_CYCLES(31'(AUTO_CYC))) sdm_measure_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .count_clock_100x(count_clock_100x),
    .data_under_test(data_under_test), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bit_phase_timing(bit_phase_timing), .capture_strobe(capture_strobe),
    .polarity_marking(polarity_marking), .start_transition_window(start_transition_window),
    .peak_enable_flag(peak_enable_flag), .add_one_compensation(add_one_compensation),
    .distortion_bcd(distortion_bcd), .transition_lines_n(transition_lines_n));
  sdm_line_model sdm_line_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .count_clock_100x(count_clock_100x), .data_under_test(data_under_test));
  always #2 sys_clk = ~sys_clk;
  // Count clock holds each level four cycles, above the two-cycle minimum
  always @(posedge sys_clk) begin
    div_cnt <= div_cnt + 3'h1;
    if (div_cnt[1:0] == 2'h3) begin
      count_clock_100x <= ~count_clock_100x;
    end
    if (capture_strobe === 1'b1) begin
      strobes++;
    end
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end
  function automatic logic [3:0] enc(input int v);
    return (v > 4) ? 4'(v + 6) : 4'(v);
  endfunction : enc
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rd_val = reg_rdata;
  endtask : rd
  // Edge at count c; capture takes the count held up to the next step
  task automatic measure(input int c, input logic lvl, input int exp_cap);
    int k;
    int disp;
    int s0;
    k    = c;
    disp = (k >= 50) ? k - 50 : 50 - k;
    s0   = strobes;
    sdm_line_model_i.move_at(7'(c), lvl);
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHECK(strobes - s0, exp_cap)
    if (exp_cap == 1 && sync_on) begin
      `CHECK(distortion_bcd, {enc(disp / 10), enc(disp % 10)})
      `CHECK(add_one_compensation, 1'(k < 50))
      `CHECK(polarity_marking, 1'(c >= 50))
    end
  endtask : measure
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    `CHECK(start_transition_window, 1'b1)
    `CHECK(transition_lines_n, 9'h1FF)
    rd(4'hC);
    `CHECK(rd_val, 32'h0)
    $display("reset test done");
    // Walk 64 steps across the 49/50 boundary and the 99 wrap
    while (sdm_line_model_i.steps != 7'd40) @(posedge sys_clk);
    for (int i = 0; i < 64; i++) begin
      n = int'(sdm_line_model_i.steps);
      do @(posedge sys_clk);
      while (int'(sdm_line_model_i.steps) == n);
      n = int'(sdm_line_model_i.steps);
      rd(sdm_pkg::ADDR_COUNT);
      `CHECK(rd_val[7:0], {enc(n / 10), enc(n % 10)})
      `CHECK(bit_phase_timing, 1'(n >= 50))
    end
    $display("counter test done");
    wr(sdm_pkg::ADDR_CTRL, 32'h41);
    measure(59, 1'b0, 1);
    measure(39, 1'b1, 0);
    measure(29, 1'b0, 1);
    wr(sdm_pkg::ADDR_CTRL, 32'h141);
    wr(sdm_pkg::ADDR_CTRL, 32'h41);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHECK(distortion_bcd, 8'h00)
    wr(sdm_pkg::ADDR_CTRL, 32'h40);
    measure(70, 1'b1, 0);
    $display("bias test done");
    wr(sdm_pkg::ADDR_CTRL, 32'h43);
    measure(69, 1'b0, 1);
    `CHECK(peak_enable_flag, 1'b1)
    measure(59, 1'b1, 0);
    `CHECK(peak_enable_flag, 1'b0)
    measure(79, 1'b0, 1);
    wr(sdm_pkg::ADDR_CTRL, 32'hC3);
    repeat (2 * AUTO_CYC + 4) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHECK(distortion_bcd, 8'h00)
    $display("peak test done");
    wr(sdm_pkg::ADDR_CTRL, 32'h42);
    measure(59, 1'b1, 0);
    measure(10, 1'b0, 0);
    measure(20, 1'b1, 0);
    sync_on = 1'b0;
    wr(sdm_pkg::ADDR_CTRL, 32'h02);
    measure(30, 1'b0, 0);
    `CHECK(transition_lines_n, 9'h1FE)
    rd(sdm_pkg::ADDR_COUNT);
    `CHECK(rd_val[11:4], 8'h10)
    measure(80, 1'b1, 1);
    wr(sdm_pkg::ADDR_CTRL, 32'h0E);
    measure(90, 1'b0, 0);
    wr(sdm_pkg::ADDR_CTRL, 32'h0A);
    measure(95, 1'b1, 1);
    $display("end test done");
    tally_and_finish();
  end
endmodule : tb_sdm_measure
`default_nettype wire
